// ---- verilog/crs_pkg.sv ----
package crs_pkg;

    // ***************************************************
    // Register byte offsets
    // ***************************************************
    localparam logic [7:0] CRS_CTRL_OFS   = 8'h00;
    localparam logic [7:0] CRS_PC_OFS     = 8'h04;
    localparam logic [7:0] CRS_OPW_OFS    = 8'h08;
    localparam logic [7:0] CRS_ABORT_OFS  = 8'h0C;
    localparam logic [7:0] CRS_STATUS_OFS = 8'h10;

    // ***************************************************
    // Control and status field positions
    // ***************************************************
    localparam int CRS_CTRL_START = 0;
    localparam int CRS_CTRL_COND  = 1;
    localparam int CRS_CTRL_TRACE = 2;
    localparam int CRS_CTRL_SUPER = 3;

    localparam int CRS_ST_BUSY   = 0;
    localparam int CRS_ST_DONE   = 1;
    localparam int CRS_ST_TF     = 2;
    localparam int CRS_ST_PROTO  = 3;
    localparam int CRS_ST_PRIV   = 4;
    localparam int CRS_ST_TRACE  = 5;
    localparam int CRS_ST_UNSUP  = 6;
    localparam int CRS_ST_PRIM_L = 16;

    // ***************************************************
    // Reset values
    // ***************************************************
    localparam logic [31:0] CRS_PC_RST    = 32'h0000_0000;
    localparam logic [15:0] CRS_OPW_RST   = 16'h0000;
    localparam logic [15:0] CRS_ABORT_RST = 16'h0001;

    // ***************************************************
    // Primitive fields and encodings
    // ***************************************************
    localparam int CRS_P_CA = 15;
    localparam int CRS_P_PC = 14;
    localparam int CRS_P_IA = 8;
    localparam int CRS_P_PF = 1;
    localparam int CRS_P_TF = 0;

    localparam logic [13:0] CRS_NULL_MASK = 14'h3EFC;
    localparam logic [13:0] CRS_NULL_CODE = 14'h0800;
    localparam logic [13:0] CRS_SUP_CODE  = 14'h0400;
    localparam logic [13:0] CRS_TOPW_CODE = 14'h0700;

    // ***************************************************
    // Coprocessor interface register selects and sequencer state encodings
    // ***************************************************
    typedef enum logic [1:0] {
        CRS_SEL_RESP  = 2'b00,
        CRS_SEL_CTRL  = 2'b01,
        CRS_SEL_IADDR = 2'b10,
        CRS_SEL_OPW   = 2'b11
    } crs_sel_t;

    typedef enum logic [2:0] {
        CRS_IDLE   = 3'b000,
        CRS_READ   = 3'b001,
        CRS_DECODE = 3'b010,
        CRS_WR_PC  = 3'b011,
        CRS_INTSVC = 3'b100,
        CRS_WR_OPW = 3'b101,
        CRS_WR_ABT = 3'b110
    } crs_state_t;

endpackage

// ---- verilog/crs_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none

module crs_sequencer
    import crs_pkg::*;
(
    // APB slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Coprocessor interface register access
    output logic             cp_req,
    output logic             cp_we,
    output logic      [1:0]  cp_sel,
    output logic      [31:0] cp_wdata,
    input  wire logic        cp_ack,
    input  wire logic [15:0] cp_rdata,
    // Interrupt service handshake
    output logic             int_service_req,
    input  wire logic        int_service_done
);

    // ***************************************************
    // Registers
    // ***************************************************
    crs_state_t  state;
    logic        conditional;
    logic        trace_pending;
    logic        supervisor;
    logic [31:0] prog_counter;
    logic [15:0] op_word;
    logic [15:0] abort_mask;
    logic [15:0] prim;
    logic        handoff_done;
    logic        done;
    logic        cond_result;
    logic        proto_viol;
    logic        priv_viol;
    logic        trace_taken;
    logic        unsupported;

    logic        apb_wr;
    logic        start;
    logic        is_null;
    logic        is_sup;
    logic        is_topw;
    logic        ca;
    logic        ia;
    logic        pf;

    assign apb_wr  = psel && penable && pwrite;
    assign start   = apb_wr && (paddr == CRS_CTRL_OFS) && pwdata[CRS_CTRL_START]
                     && (state == CRS_IDLE);
    assign pready  = 1'b1;

    assign is_null = (prim[13:0] & CRS_NULL_MASK) == CRS_NULL_CODE;
    assign is_sup  = prim[13:0] == CRS_SUP_CODE;
    assign is_topw = prim[13:0] == CRS_TOPW_CODE;
    assign ca      = prim[CRS_P_CA];
    assign ia      = prim[CRS_P_IA];
    assign pf      = prim[CRS_P_PF];

    // ***************************************************
    // APB decode
    // ***************************************************
    always_comb begin
        prdata  = 32'h0000_0000;
        pslverr = 1'b0;
        if (paddr == CRS_CTRL_OFS) begin
            prdata[CRS_CTRL_COND]  = conditional;
            prdata[CRS_CTRL_TRACE] = trace_pending;
            prdata[CRS_CTRL_SUPER] = supervisor;
        end else if (paddr == CRS_PC_OFS) begin
            prdata = prog_counter;
        end else if (paddr == CRS_OPW_OFS) begin
            prdata[15:0] = op_word;
        end else if (paddr == CRS_ABORT_OFS) begin
            prdata[15:0] = abort_mask;
        end else if (paddr == CRS_STATUS_OFS) begin
            prdata[CRS_ST_BUSY]  = state != CRS_IDLE;
            prdata[CRS_ST_DONE]  = done;
            prdata[CRS_ST_TF]    = cond_result;
            prdata[CRS_ST_PROTO] = proto_viol;
            prdata[CRS_ST_PRIV]  = priv_viol;
            prdata[CRS_ST_TRACE] = trace_taken;
            prdata[CRS_ST_UNSUP] = unsupported;
            prdata[CRS_ST_PRIM_L +: 16] = prim;
        end else begin
            pslverr = psel && penable;
        end
    end

    // Settings are frozen while a dialogue is running.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conditional   <= 1'b0;
            trace_pending <= 1'b0;
            supervisor    <= 1'b0;
            prog_counter  <= CRS_PC_RST;
            op_word       <= CRS_OPW_RST;
            abort_mask    <= CRS_ABORT_RST;
        end else if (apb_wr && state == CRS_IDLE) begin
            if (paddr == CRS_CTRL_OFS) begin
                conditional   <= pwdata[CRS_CTRL_COND];
                trace_pending <= pwdata[CRS_CTRL_TRACE];
                supervisor    <= pwdata[CRS_CTRL_SUPER];
            end else if (paddr == CRS_PC_OFS) begin
                prog_counter <= pwdata;
            end else if (paddr == CRS_OPW_OFS) begin
                op_word <= pwdata[15:0];
            end else if (paddr == CRS_ABORT_OFS) begin
                abort_mask <= pwdata[15:0];
            end
        end
    end

    // ***************************************************
    // Response sequencer
    // ***************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state        <= CRS_IDLE;
            prim         <= 16'h0000;
            handoff_done <= 1'b0;
            done         <= 1'b0;
            cond_result  <= 1'b0;
            proto_viol   <= 1'b0;
            priv_viol    <= 1'b0;
            trace_taken  <= 1'b0;
            unsupported  <= 1'b0;
        end else begin
            case (state)
                CRS_IDLE: begin
                    if (start) begin
                        done        <= 1'b0;
                        cond_result <= 1'b0;
                        proto_viol  <= 1'b0;
                        priv_viol   <= 1'b0;
                        trace_taken <= 1'b0;
                        unsupported <= 1'b0;
                        state       <= CRS_READ;
                    end
                end
                CRS_READ: begin
                    if (cp_ack) begin
                        prim         <= cp_rdata;
                        handoff_done <= 1'b0;
                        state        <= CRS_DECODE;
                    end
                end
                CRS_WR_PC: begin
                    if (cp_ack) begin
                        handoff_done <= 1'b1;
                        state        <= CRS_DECODE;
                    end
                end
                CRS_INTSVC: begin
                    if (int_service_done) begin
                        state <= CRS_READ;
                    end
                end
                CRS_WR_OPW: begin
                    if (cp_ack) begin
                        if (ca) begin
                            state <= CRS_READ;
                        end else if (conditional) begin
                            proto_viol <= 1'b1;
                            done       <= 1'b1;
                            state      <= CRS_IDLE;
                        end else if (trace_pending) begin
                            state <= CRS_READ;
                        end else begin
                            done  <= 1'b1;
                            state <= CRS_IDLE;
                        end
                    end
                end
                CRS_WR_ABT: begin
                    if (cp_ack) begin
                        priv_viol <= 1'b1;
                        done      <= 1'b1;
                        state     <= CRS_IDLE;
                    end
                end
                CRS_DECODE: begin
                    if (prim[CRS_P_PC] && !handoff_done) begin
                        state <= CRS_WR_PC;
                    end else if (is_null) begin
                        if (ca) begin
                            state <= ia ? CRS_INTSVC : CRS_READ;
                        end else if (conditional) begin
                            cond_result <= prim[CRS_P_TF];
                            done        <= 1'b1;
                            state       <= CRS_IDLE;
                        end else if (trace_pending && pf) begin
                            trace_taken <= 1'b1;
                            done        <= 1'b1;
                            state       <= CRS_IDLE;
                        end else if (trace_pending) begin
                            state <= ia ? CRS_INTSVC : CRS_READ;
                        end else begin
                            done  <= 1'b1;
                            state <= CRS_IDLE;
                        end
                    end else if (is_sup) begin
                        if (conditional && !ca) begin
                            proto_viol <= 1'b1;
                            done       <= 1'b1;
                            state      <= CRS_IDLE;
                        end else if (!supervisor) begin
                            state <= CRS_WR_ABT;
                        end else begin
                            state <= CRS_READ;
                        end
                    end else if (is_topw) begin
                        state <= CRS_WR_OPW;
                    end else begin
                        // Primitives outside this block end the dialogue flagged.
                        unsupported <= 1'b1;
                        done        <= 1'b1;
                        state       <= CRS_IDLE;
                    end
                end
                default: begin
                    state <= CRS_IDLE;
                end
            endcase
        end
    end

    // ***************************************************
    // Coprocessor access and interrupt request
    // ***************************************************
    always_comb begin
        cp_req   = 1'b0;
        cp_we    = 1'b0;
        cp_sel   = CRS_SEL_RESP;
        cp_wdata = 32'h0000_0000;
        case (state)
            CRS_READ: begin
                cp_req = 1'b1;
            end
            CRS_WR_PC: begin
                cp_req   = 1'b1;
                cp_we    = 1'b1;
                cp_sel   = CRS_SEL_IADDR;
                cp_wdata = prog_counter;
            end
            CRS_WR_OPW: begin
                cp_req   = 1'b1;
                cp_we    = 1'b1;
                cp_sel   = CRS_SEL_OPW;
                cp_wdata = {16'h0000, op_word};
            end
            CRS_WR_ABT: begin
                cp_req   = 1'b1;
                cp_we    = 1'b1;
                cp_sel   = CRS_SEL_CTRL;
                cp_wdata = {16'h0000, abort_mask};
            end
            default: begin
                cp_req = 1'b0;
            end
        endcase
    end

    assign int_service_req = state == CRS_INTSVC;

endmodule

`default_nettype wire

// ---- tb/crs_sequencer_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module crs_sequencer_monitor
    import crs_pkg::*;
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // Coprocessor port
    input wire logic        cp_req,
    input wire logic        cp_we,
    input wire logic [1:0]  cp_sel,
    input wire logic [31:0] cp_wdata,
    input wire logic        cp_ack,
    input wire logic [15:0] cp_rdata,
    // Interrupt handshake
    input wire logic        int_service_req,
    input wire logic        int_service_done
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic rd_ack;
    logic is_null;
    logic ca_null;
    logic unsup;
    assign rd_ack  = cp_req && !cp_we && cp_ack;
    assign is_null = (cp_rdata[13:0] & CRS_NULL_MASK) == CRS_NULL_CODE;
    assign ca_null = rd_ack && is_null && cp_rdata[15:14] == 2'b10;
    assign unsup   = rd_ack && !cp_rdata[CRS_P_PC] && !is_null
                     && cp_rdata[13:0] != CRS_SUP_CODE && cp_rdata[13:0] != CRS_TOPW_CODE;

    // *****
    // Access sequencing
    // *****
    // request held
    a_req_held: assert property (cp_req && !cp_ack |=> cp_req && $stable({cp_we, cp_sel, cp_wdata}))
        else $error("request changed before acknowledge");
    a_req_gap: assert property (cp_req && cp_ack && !(cp_we && cp_sel == CRS_SEL_OPW) |=> !cp_req)
        else $error("no idle cycle after access");
    a_opw_next: assert property (cp_req && cp_ack && cp_we && cp_sel == CRS_SEL_OPW |=>
        !cp_req || (!cp_we && cp_sel == CRS_SEL_RESP))
        else $error("wrong access after operation word copy");
    a_ca_reread: assert property (ca_null && !cp_rdata[CRS_P_IA] |=>
        !int_service_req throughout (##[1:4] (cp_req && !cp_we && cp_sel == CRS_SEL_RESP)))
        else $error("come-again without service not reread");
    a_ca_service: assert property (ca_null && cp_rdata[CRS_P_IA] |-> ##[1:4] int_service_req)
        else $error("interrupt service not requested");
    a_svc_held: assert property (int_service_req && !int_service_done |=> int_service_req)
        else $error("service request dropped early");
    a_svc_no_read: assert property (int_service_req |-> !cp_req)
        else $error("access during interrupt service");
    a_pc_first: assert property (rd_ack && cp_rdata[CRS_P_PC] |->
        ##[1:5] (cp_req && cp_we && cp_sel == CRS_SEL_IADDR))
        else $error("program counter not passed");
    a_opw_copy: assert property (rd_ack && !cp_rdata[CRS_P_PC]
        && cp_rdata[13:0] == CRS_TOPW_CODE |-> ##[1:5] (cp_req && cp_we && cp_sel == CRS_SEL_OPW))
        else $error("operation word not copied");
    a_unsup_end: assert property (unsup |=> !cp_req [*6])
        else $error("dialogue went on after unknown primitive");

    c_ca_service: cover property (ca_null && cp_rdata[CRS_P_IA]);
    c_abort_wr: cover property (cp_req && cp_we && cp_ack && cp_sel == CRS_SEL_CTRL);
    c_opw_wr: cover property (cp_req && cp_we && cp_ack && cp_sel == CRS_SEL_OPW);
endmodule

bind crs_sequencer crs_sequencer_monitor crs_sequencer_monitor_i (.pclk, .presetn, .cp_req,
    .cp_we, .cp_sel, .cp_wdata, .cp_ack, .cp_rdata, .int_service_req, .int_service_done);
`default_nettype wire

// ---- tb/crs_copro_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module crs_copro_model (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Interface register access
    input  wire logic        cp_req,
    input  wire logic        cp_we,
    input  wire logic [1:0]  cp_sel,
    input  wire logic [31:0] cp_wdata,
    output var  logic        cp_ack,
    output var  logic [15:0] cp_rdata
);
    logic [15:0] prims[$];
    logic [1:0]  wsel[$];
    logic [31:0] wdat[$];
    int          wait_n;
    logic        slow;

    task automatic push(input logic [15:0] p);
        prims.push_back(p);
    endtask

    // *****
    // Responder
    // *****
    // Answers alternate prompt and slow; the data line churns while no request is pending and after each answer, and holds while a request waits.
    // composed words served
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cp_ack <= 1'b0;
            cp_rdata <= 16'hA5A5;
            wait_n = 0;
            slow = 1'b0;
        end else if (cp_ack || !cp_req) begin
            cp_ack <= 1'b0;
            cp_rdata <= ~cp_rdata;
        end else if (wait_n < (slow ? 3 : 0)) begin
            wait_n++;
        end else begin
            wait_n = 0;
            slow = !slow;
            cp_ack <= 1'b1;
            if (cp_we) begin
                wsel.push_back(cp_sel);
                wdat.push_back(cp_wdata);
            end else begin
                cp_rdata <= (prims.size() > 0) ? prims.pop_front() : 16'h0800;
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/crs_sequencer_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module crs_sequencer_tb
    import crs_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, cp_wdata, rd;
    logic        cp_req, cp_we, cp_ack, int_service_req, int_service_done;
    logic [1:0]  cp_sel;
    logic [15:0] cp_rdata;
    int          failures, n_compared, n_int;

    crs_sequencer crs_sequencer_i (.*);
    crs_copro_model crs_copro_model_i (.*);

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // Interrupt service answers each request once.
    always @(posedge pclk) begin
        int_service_done <= (int_service_req === 1'b1 && int_service_done !== 1'b1);
        if (int_service_req === 1'b1 && int_service_done !== 1'b1) begin
            n_int++;
        end
    end

    // *****
    // Tasks
    // *****
    task automatic finish_test();
        if (failures == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Data and error are taken at the edge that sees pready high.
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic run_case(input logic [3:0] ctl, input logic [15:0] p0, input logic [15:0] p1,
        input logic [31:0] st, input logic [31:0] msk, input int nw, input logic [1:0] sel,
        input logic [31:0] wd, input int ni);
        int t0;
        t0 = n_int;
        crs_copro_model_i.prims.delete();
        crs_copro_model_i.wsel.delete();
        crs_copro_model_i.wdat.delete();
        crs_copro_model_i.push(p0);
        if (p1 !== 16'h0000) crs_copro_model_i.push(p1);
        apb(1'b1, CRS_CTRL_OFS, {28'h0, ctl} | 32'h1);
        rd = 32'h1;
        for (int k = 0; k < 40 && rd[CRS_ST_BUSY] !== 1'b0; k++) apb(1'b0, CRS_STATUS_OFS, 32'h0);
        check({31'h0, rd[CRS_ST_BUSY]}, 32'h0);
        check(rd & msk, st);
        check(32'(crs_copro_model_i.wdat.size()), 32'(nw));
        if (nw > 0) begin
            check({30'h0, crs_copro_model_i.wsel[0]}, {30'h0, sel});
            rd = crs_copro_model_i.wdat[0];
            check(sel == CRS_SEL_IADDR ? rd : {16'h0, rd[15:0]}, wd);
        end
        check(32'(n_int - t0), 32'(ni));
    endtask

    // *****
    // Main sequence
    // *****
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, CRS_STATUS_OFS, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, CRS_ABORT_OFS, 32'h0);
        check(rd, {16'h0, CRS_ABORT_RST});
        apb(1'b0, 8'h14, 32'h0);
        check({31'h0, err}, 32'h1);
        apb(1'b1, CRS_PC_OFS, 32'h1234_5678);
        apb(1'b1, CRS_OPW_OFS, 32'h0000_ABCD);
        apb(1'b1, CRS_ABORT_OFS, 32'h0000_00F1);
        apb(1'b0, CRS_PC_OFS, 32'h0);
        check(rd, 32'h1234_5678);
        run_case(4'h0, 16'h0800, 16'h0, 32'h0800_0002, 32'hFFFF_007E, 0, 2'b00, 0, 0);
        run_case(4'h2, 16'h8800, 16'h0801, 32'h0801_0006, 32'hFFFF_007E, 0, 2'b00, 0, 0);
        run_case(4'h0, 16'h8900, 16'h0802, 32'h0802_0002, 32'hFFFF_007E, 0, 2'b00, 0, 1);
        run_case(4'h4, 16'h0900, 16'h0802, 32'h0802_0020, 32'hFFFF_007C, 0, 2'b00, 0, 1);
        run_case(4'h0, 16'h4800, 16'h0, 32'h0000_0002, 32'h0000_007E, 1, 2'b10,
            32'h1234_5678, 0);
        run_case(4'h0, 16'h8400, 16'h0, 32'h8400_0010, 32'hFFFF_007C, 1, 2'b01,
            32'h0000_00F1, 0);
        run_case(4'h8, 16'h8400, 16'h0800, 32'h0800_0002, 32'hFFFF_007E, 0, 2'b00, 0, 0);
        run_case(4'h8, 16'h0400, 16'h0800, 32'h0800_0002, 32'hFFFF_007E, 0, 2'b00, 0, 0);
        run_case(4'hA, 16'h0400, 16'h0, 32'h0400_0008, 32'hFFFF_007C, 0, 2'b00, 0, 0);
        run_case(4'h0, 16'h8700, 16'h0800, 32'h0800_0002, 32'hFFFF_007E, 1, 2'b11,
            32'h0000_ABCD, 0);
        run_case(4'h2, 16'h0700, 16'h0, 32'h0700_0008, 32'hFFFF_007C, 1, 2'b11,
            32'h0000_ABCD, 0);
        run_case(4'h0, 16'hA400, 16'h0, 32'hA400_0040, 32'hFFFF_007C, 0, 2'b00, 0, 0);
        finish_test();
    end

    initial begin
        #20000;
        failures++;
        finish_test();
    end
endmodule
`default_nettype wire
